// >>> logic/eep_control.sv
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module eep_control #(
	parameter int PROG_CYCLES = eep_pkg::PROG_CYCLES,
	parameter int TICK_DIV = eep_pkg::TICK_DIV,
	parameter int BYTES = 128
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic [31:0] o_prdata,
	output logic o_pslverr,
	// interrupt
	output logic o_irq
);
	localparam int PW = $clog2(PROG_CYCLES + 1);
	localparam int AW = $clog2(BYTES);

	eep_pkg::eep_ctrl_type ctrl_q;
	eep_pkg::eep_state_type state_q;
	logic [7:0] addr_q;
	logic [7:0] reload_q;
	logic [1:0] sts_q;
	logic [1:0] msk_q;
	logic [PW-1:0] phase_q;
	logic [7:0] mem [BYTES];
	logic [7:0] latch_data [4];
	logic [3:0] latch_flag;
	logic [7:0] count;
	logic underflow;
	logic [7:0] idx;
	logic in_range;
	logic hit_addr, hit_ctrl, hit_data, hit_reload, hit_sts, hit_msk, hit_count;
	logic mapped;
	logic wr, rd;
	logic start;
	logic run_load;
	logic phase_end;
	logic erase_fire, write_fire, done;
	logic data_wr, data_rd;
	logic [2:0] new_mode;
	logic [7:0] rd_value;

	// address decode, low two bits ignored
	assign idx = i_paddr[9:2];
	assign in_range = (i_paddr[11:10] == 2'h0);
	assign hit_addr = in_range && (idx == eep_pkg::IDX_ADDR);
	assign hit_ctrl = in_range && (idx == eep_pkg::IDX_CTRL);
	assign hit_data = in_range && (idx == eep_pkg::IDX_DATA);
	assign hit_reload = in_range && (idx == eep_pkg::IDX_RELOAD);
	assign hit_sts = in_range && (idx == eep_pkg::IDX_STATUS);
	assign hit_msk = in_range && (idx == eep_pkg::IDX_MASK);
	assign hit_count = in_range && (idx == eep_pkg::IDX_COUNT);
	assign mapped = hit_addr || hit_ctrl || hit_data || hit_reload || hit_sts || hit_msk
		|| hit_count;

	// zero wait states; unmapped access answers with an error
	assign o_pready = 1'b1;
	assign o_pslverr = i_psel && i_penable && !mapped;
	assign wr = i_psel && i_penable && i_pwrite && mapped;
	assign rd = i_psel && i_penable && !i_pwrite && mapped;

	// mode decode; forbidden codes never start a cycle
	assign new_mode = i_pwdata[3:1];
	assign start = wr && hit_ctrl && i_pwdata[4] && !ctrl_q.busy
		&& ((new_mode[2:1] == eep_pkg::MODE_WRITE_HI)
		|| (new_mode == eep_pkg::MODE_ERASE_WRITE)
		|| (new_mode == eep_pkg::MODE_ERASE));
	assign run_load = start || (wr && hit_ctrl && i_pwdata[7] && !ctrl_q.run);

	// page setup and the pointer step of data reads are locked out while a cycle runs
	assign data_wr = wr && hit_data && !ctrl_q.busy;
	assign data_rd = rd && hit_data && !ctrl_q.busy;

	// sequencer timing
	assign phase_end = (state_q != eep_pkg::ST_IDLE) && (phase_q == PW'(PROG_CYCLES - 1));
	assign erase_fire = phase_end && (state_q == eep_pkg::ST_ERASE);
	assign write_fire = phase_end && (state_q == eep_pkg::ST_WRITE);
	assign done = write_fire
		|| (erase_fire && (ctrl_q.mode != eep_pkg::MODE_ERASE_WRITE));

	// timer, started by software or by a program cycle
	eep_down_counter #(
		.WIDTH(8),
		.TICK_DIV(TICK_DIV)
	) u_counter (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_load(run_load),
		.i_run(ctrl_q.run || ctrl_q.busy),
		.i_reload(reload_q),
		.o_count(count),
		.o_underflow(underflow)
	);

	// one latch per page byte, selected by the low address bits
	for (genvar g = 0; g < 4; g++)
	begin : g_latch
		eep_page_latch #(
			.WIDTH(8)
		) u_latch (
			.i_clock(i_clock),
			.i_reset_n(i_reset_n),
			.i_clear(done),
			.i_load(data_wr && (addr_q[1:0] == 2'(g))),
			.i_data(i_pwdata[7:0]),
			.o_data(latch_data[g]),
			.o_flag(latch_flag[g])
		);
	end

	// sequencer: erase phase, write phase, or erase then write
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
			state_q <= eep_pkg::ST_IDLE;
		else
		begin
			case (state_q)
				eep_pkg::ST_IDLE:
					if (start)
						state_q <= (new_mode[2:1] == eep_pkg::MODE_WRITE_HI)
							? eep_pkg::ST_WRITE : eep_pkg::ST_ERASE;
				eep_pkg::ST_ERASE:
					if (erase_fire)
						state_q <= (ctrl_q.mode == eep_pkg::MODE_ERASE_WRITE)
							? eep_pkg::ST_WRITE : eep_pkg::ST_IDLE;
				eep_pkg::ST_WRITE:
					if (write_fire)
						state_q <= eep_pkg::ST_IDLE;
				default:
					state_q <= eep_pkg::ST_IDLE;
			endcase
		end
	end

	// each phase lasts the full programming time
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
			phase_q <= '0;
		else if (start || phase_end)
			phase_q <= '0;
		else if (state_q != eep_pkg::ST_IDLE)
			phase_q <= phase_q + 1'b1;
	end

	// array is nonvolatile, so it has no reset; flags pick bytes
	always_ff @(posedge i_clock)
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (erase_fire && latch_flag[i])
				mem[{addr_q[AW-1:2], 2'(i)}] <= 8'h00;
			else if (write_fire && latch_flag[i])
				mem[{addr_q[AW-1:2], 2'(i)}] <= mem[{addr_q[AW-1:2], 2'(i)}]
					| latch_data[i];
		end
	end

	// pointer: data reads and write cycles step it, erase leaves it
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
			addr_q <= eep_pkg::ADDR_RESET;
		else if (write_fire || data_rd)
			addr_q <= addr_q + 8'h01;
		else if (wr && hit_addr && !ctrl_q.busy)
			addr_q <= {1'b0, i_pwdata[6:0]};
		else if (data_wr && (ctrl_q.mode == eep_pkg::MODE_INCR) && (addr_q[1:0] != 2'h3))
			addr_q[1:0] <= addr_q[1:0] + 2'h1;
	end

	// control register; hardware set of the flag beats a clear
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
			ctrl_q <= eep_pkg::CTRL_RESET;
		else
		begin
			if (wr && hit_ctrl)
			begin
				ctrl_q.run <= i_pwdata[7];
				ctrl_q.irq_enable <= i_pwdata[6];
				ctrl_q.underflow_flag <= i_pwdata[5] || underflow;
				if (!ctrl_q.busy)
					ctrl_q.mode <= new_mode;
			end
			else if (underflow)
				ctrl_q.underflow_flag <= 1'b1;
			if (start)
				ctrl_q.busy <= 1'b1;
			else if (done)
				ctrl_q.busy <= 1'b0;
			ctrl_q.zero <= 1'b0;
		end
	end

	// reload register, held during a cycle
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
			reload_q <= eep_pkg::RELOAD_RESET;
		else if (wr && hit_reload && !ctrl_q.busy)
			reload_q <= i_pwdata[7:0];
	end

	// sticky events, write one to clear, new event wins
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			sts_q <= eep_pkg::STATUS_RESET;
			msk_q <= eep_pkg::STATUS_RESET;
		end
		else
		begin
			sts_q[eep_pkg::STS_UNDERFLOW_BIT] <= (sts_q[eep_pkg::STS_UNDERFLOW_BIT]
				&& !(wr && hit_sts && i_pwdata[eep_pkg::STS_UNDERFLOW_BIT]))
				|| (underflow && ctrl_q.irq_enable);
			sts_q[eep_pkg::STS_DONE_BIT] <= (sts_q[eep_pkg::STS_DONE_BIT]
				&& !(wr && hit_sts && i_pwdata[eep_pkg::STS_DONE_BIT])) || done;
			if (wr && hit_msk)
				msk_q <= i_pwdata[1:0];
		end
	end

	assign o_irq = |(sts_q & msk_q);

	// read data chosen now, captured in the setup cycle
	always_comb
	begin
		rd_value = 8'h00;
		if (hit_addr)
			rd_value = addr_q;
		else if (hit_ctrl)
			rd_value = {ctrl_q[7:1], 1'b0};
		else if (hit_data)
			rd_value = mem[addr_q[AW-1:0]];
		else if (hit_reload)
			rd_value = reload_q;
		else if (hit_sts)
			rd_value = {6'h00, sts_q};
		else if (hit_msk)
			rd_value = {6'h00, msk_q};
		else if (hit_count)
			rd_value = count;
	end

	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_prdata <= 32'h0000_0000;
		else if (i_psel && !i_penable && !i_pwrite)
			o_prdata <= {24'h00_0000, rd_value};
	end

	// checks
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_reset_n);

	sequence s_ew_erase_end;
		erase_fire && (ctrl_q.mode == eep_pkg::MODE_ERASE_WRITE);
	endsequence

	sequence s_erase_only_end;
		erase_fire && (ctrl_q.mode == eep_pkg::MODE_ERASE);
	endsequence

	a_phase_len: assert property (
		(state_q != eep_pkg::ST_IDLE) && !phase_end |=> $stable(state_q))
		else $error("phase ended early");
	a_ew_order: assert property (
		s_ew_erase_end |=> (state_q == eep_pkg::ST_WRITE) && (phase_q == '0) && ctrl_q.busy)
		else $error("erase/write skipped write");
	a_erase_addr: assert property (
		s_erase_only_end |=> $stable(addr_q) && !ctrl_q.busy)
		else $error("erase moved pointer");
	a_read_step: assert property (
		data_rd |=> addr_q == $past(addr_q) + 8'h01)
		else $error("pointer did not step on read");
	a_busy_start: assert property (
		start |=> ctrl_q.busy && (state_q != eep_pkg::ST_IDLE))
		else $error("start not taken");
	a_flag_sticky: assert property (
		ctrl_q.underflow_flag && !(wr && hit_ctrl) |=> ctrl_q.underflow_flag)
		else $error("flag cleared by hardware");
	a_ctrl_bit0: assert property (
		i_psel && !i_penable && !i_pwrite && hit_ctrl
		|=> o_prdata[7:0] == {$past(ctrl_q[7:1]), 1'b0})
		else $error("control bit 0 read as one");
	a_done_irq: assert property (
		done && msk_q[eep_pkg::STS_DONE_BIT] && !(wr && hit_msk) |=> o_irq && !ctrl_q.busy)
		else $error("completion not signalled");
endmodule // eep_control

// >>> logic/eep_pkg.sv
package eep_pkg;
	// register word indices, byte address is four times the index
	localparam logic [7:0] IDX_ADDR = 8'h01;
	localparam logic [7:0] IDX_CTRL = 8'h02;
	localparam logic [7:0] IDX_DATA = 8'h03;
	localparam logic [7:0] IDX_RELOAD = 8'h04;
	localparam logic [7:0] IDX_STATUS = 8'h05;
	localparam logic [7:0] IDX_MASK = 8'h06;
	localparam logic [7:0] IDX_COUNT = 8'h07;

	// operation codes in the mode field
	localparam logic [2:0] MODE_READ = 3'h0;
	localparam logic [2:0] MODE_INCR = 3'h2;
	localparam logic [2:0] MODE_ERASE_WRITE = 3'h4;
	localparam logic [2:0] MODE_ERASE = 3'h7;
	localparam logic [1:0] MODE_WRITE_HI = 2'h1;

	// event bits in status and mask
	localparam int STS_UNDERFLOW_BIT = 0;
	localparam int STS_DONE_BIT = 1;

	// values after reset
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] ADDR_RESET = 8'h00;
	localparam logic [7:0] RELOAD_RESET = 8'hFF;
	localparam logic [1:0] STATUS_RESET = 2'h0;

	// timing
	localparam int CLOCK_PERIOD_NS = 40;
	localparam int PROG_TIME_NS = 5000000;
	localparam int PROG_CYCLES = (PROG_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
	localparam int TICK_DIV = 489;

	// control register layout
	typedef struct packed {
		logic run;
		logic irq_enable;
		logic underflow_flag;
		logic busy;
		logic [2:0] mode;
		logic zero;
	} eep_ctrl_type;

	// program sequencer states
	typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE} eep_state_type;
endpackage

// >>> logic/eep_page_latch.sv
`timescale 1ns/100ps
module eep_page_latch #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// control
	input wire logic i_clear,
	input wire logic i_load,
	input wire logic [WIDTH-1:0] i_data,
	// state
	output logic [WIDTH-1:0] o_data,
	output logic o_flag
);
	// latch can only be preset, so loads accumulate
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_data <= '0;
			o_flag <= 1'b0;
		end
		else if (i_clear)
		begin
			o_data <= '0;
			o_flag <= 1'b0;
		end
		else if (i_load)
		begin
			o_data <= o_data | i_data;
			o_flag <= 1'b1;
		end
	end

	a_latch_or: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		i_load && !i_clear |=> o_flag && ((o_data & $past(i_data)) == $past(i_data)))
		else $error("latch load lost bits");
endmodule // eep_page_latch

// >>> logic/eep_down_counter.sv
`timescale 1ns/100ps
module eep_down_counter #(
	parameter int WIDTH = 8,
	parameter int TICK_DIV = eep_pkg::TICK_DIV
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// control
	input wire logic i_load,
	input wire logic i_run,
	input wire logic [WIDTH-1:0] i_reload,
	// state
	output logic [WIDTH-1:0] o_count,
	output logic o_underflow
);
	localparam int DW = $clog2(TICK_DIV + 1);
	logic [DW-1:0] div_q;
	logic tick;

	// prescaler stretches the 8-bit range to cover a program cycle
	assign tick = i_run && (div_q == DW'(TICK_DIV - 1));
	assign o_underflow = tick && (o_count == '0);

	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
			div_q <= '0;
		else if (i_load || tick)
			div_q <= '0;
		else if (i_run)
			div_q <= div_q + 1'b1;
	end

	// count held while stopped, reloaded on underflow
	always_ff @(posedge i_clock or negedge i_reset_n)
	begin
		if (!i_reset_n)
			o_count <= '0;
		else if (i_load)
			o_count <= i_reload;
		else if (o_underflow)
			o_count <= i_reload;
		else if (tick)
			o_count <= o_count - 1'b1;
	end

	a_counter_hold: assert property (@(posedge i_clock) disable iff (!i_reset_n)
		!i_run && !i_load |=> $stable(o_count))
		else $error("stopped counter moved");
endmodule // eep_down_counter

// >>> tb/eep_control_tb.sv
`timescale 1ns/100ps
module eep_control_tb;
	// short program phase and fast tick keep the run brief
	localparam int PROG = 20;
	logic i_clock;
	logic i_reset_n;
	logic i_psel;
	logic i_penable;
	logic i_pwrite;
	logic [11:0] i_paddr;
	logic [31:0] i_pwdata;
	logic o_pready;
	logic [31:0] o_prdata;
	logic o_pslverr;
	logic o_irq;
	int fail_count;
	int check_count;
	int polls;
	event stim_done;
	logic [31:0] seed;
	logic [31:0] rd;
	logic err;
	logic [7:0] base;
	logic [7:0] img [4];
	logic [7:0] lat [4];

	eep_control #(.PROG_CYCLES(PROG), .TICK_DIV(2), .BYTES(128)) eep_control_i (
		.i_clock(i_clock),
		.i_reset_n(i_reset_n),
		.i_psel(i_psel),
		.i_penable(i_penable),
		.i_pwrite(i_pwrite),
		.i_paddr(i_paddr),
		.i_pwdata(i_pwdata),
		.o_pready(o_pready),
		.o_prdata(o_prdata),
		.o_pslverr(o_pslverr),
		.o_irq(o_irq)
	);

	// free-running clock
	initial
	begin
		i_clock = 1'b0;
		forever #20 i_clock = ~i_clock;
	end

	// xorshift source, repeatable from the fixed seed
	function automatic logic [31:0] nrand(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		@(posedge i_clock);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= wr;
		i_paddr <= {2'h0, idx, 2'h0};
		i_pwdata <= {24'h0, wd};
		@(posedge i_clock);
		i_penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge i_clock);
			n++;
		end while (o_pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			fail_count++;
			-> stim_done;
			disable stim;
		end
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask

	task automatic w(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask

	task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		check(rd, {24'h0, exp});
	endtask

	// poll busy with a bound; polls counts three-cycle reads
	task automatic wait_idle();
		polls = 0;
		do
		begin
			apb(1'b0, eep_pkg::IDX_CTRL, 8'h00);
			polls++;
		end while (rd[4] === 1'b1 && polls < 200);
		if (polls >= 200)
		begin
			fail_count++;
			-> stim_done;
			disable stim;
		end
	endtask

	// page setup in increment mode, latches 0..3 from lat
	task automatic load_page();
		w(eep_pkg::IDX_CTRL, 8'h04);
		w(eep_pkg::IDX_ADDR, base);
		for (int k = 0; k < 4; k++)
			w(eep_pkg::IDX_DATA, lat[k]);
	endtask

	task automatic chk_page();
		w(eep_pkg::IDX_CTRL, 8'h00);
		w(eep_pkg::IDX_ADDR, base);
		for (int k = 0; k < 4; k++)
			rchk(eep_pkg::IDX_DATA, img[k]);
		rchk(eep_pkg::IDX_ADDR, base + 8'h04);
	endtask

	task automatic rand_lat();
		for (int k = 0; k < 4; k++)
		begin
			seed = nrand(seed);
			lat[k] = seed[7:0];
		end
	endtask

	// main sequence; a timeout leaves it early for the verdict
	initial
	begin : stim
		i_reset_n = 1'b0;
		i_psel = 1'b0;
		i_penable = 1'b0;
		i_pwrite = 1'b0;
		i_paddr = 12'h000;
		i_pwdata = 32'h0;
		fail_count = 0;
		check_count = 0;
		seed = 32'h8053;
		repeat (2) @(posedge i_clock);
		i_reset_n <= 1'b1;
		rchk(eep_pkg::IDX_CTRL, eep_pkg::CTRL_RESET);
		rchk(eep_pkg::IDX_RELOAD, eep_pkg::RELOAD_RESET);
		rchk(eep_pkg::IDX_STATUS, 8'h00);
		apb(1'b0, 8'h00, 8'h00);
		check({31'h0, err}, 32'h1);
		w(eep_pkg::IDX_ADDR, 8'hFF);
		rchk(eep_pkg::IDX_ADDR, 8'h7F);
		// erase/write page copies latches, takes two phases
		seed = nrand(seed);
		base = {1'b0, seed[4:0], 2'h0};
		rand_lat();
		img = lat;
		load_page();
		w(eep_pkg::IDX_CTRL, 8'h18);
		wait_idle();
		check({31'h0, polls >= 12 && polls <= 15}, 32'h1);
		rchk(eep_pkg::IDX_STATUS, 8'h02);
		w(eep_pkg::IDX_MASK, 8'h02);
		@(posedge i_clock);
		check({31'h0, o_irq}, 32'h1);
		w(eep_pkg::IDX_STATUS, 8'h02);
		@(posedge i_clock);
		check({31'h0, o_irq}, 32'h0);
		chk_page();
		// write page only ors new ones in
		rand_lat();
		for (int k = 0; k < 4; k++)
			img[k] = img[k] | lat[k];
		load_page();
		w(eep_pkg::IDX_CTRL, 8'h14);
		wait_idle();
		check({31'h0, polls >= 6 && polls <= 8}, 32'h1);
		chk_page();
		// erase one byte alone, pointer kept by erase
		w(eep_pkg::IDX_CTRL, 8'h00);
		w(eep_pkg::IDX_ADDR, base + 8'h02);
		w(eep_pkg::IDX_DATA, 8'h00);
		w(eep_pkg::IDX_CTRL, 8'h1E);
		wait_idle();
		check({31'h0, polls >= 6 && polls <= 8}, 32'h1);
		rchk(eep_pkg::IDX_ADDR, base + 8'h02);
		img[2] = 8'h00;
		chk_page();
		// write one byte back with the other write code
		w(eep_pkg::IDX_ADDR, base + 8'h02);
		w(eep_pkg::IDX_DATA, lat[2]);
		w(eep_pkg::IDX_CTRL, 8'h16);
		wait_idle();
		check({31'h0, polls >= 6 && polls <= 8}, 32'h1);
		img[2] = lat[2];
		chk_page();
		// forbidden codes never start a cycle
		foreach (lat[m])
		begin
			w(eep_pkg::IDX_CTRL, {3'h0, 1'b1, 3'(m == 0 ? 1 : m == 1 ? 5 : 6), 1'b0});
			apb(1'b0, eep_pkg::IDX_CTRL, 8'h00);
			check({31'h0, rd[4]}, 32'h0);
		end
		// counter underflow with interrupt enabled
		w(eep_pkg::IDX_STATUS, 8'h03);
		w(eep_pkg::IDX_RELOAD, 8'h03);
		w(eep_pkg::IDX_MASK, 8'h01);
		w(eep_pkg::IDX_CTRL, 8'hC0);
		polls = 0;
		while (o_irq !== 1'b1 && polls < 40)
		begin
			@(posedge i_clock);
			polls++;
		end
		if (polls >= 40)
		begin
			fail_count++;
			-> stim_done;
			disable stim;
		end
		check({31'h0, o_irq}, 32'h1);
		repeat (3)
		begin
			apb(1'b0, eep_pkg::IDX_COUNT, 8'h00);
			check({31'h0, rd <= 32'h3}, 32'h1);
		end
		w(eep_pkg::IDX_CTRL, 8'h60);
		rchk(eep_pkg::IDX_CTRL, 8'h60);
		w(eep_pkg::IDX_CTRL, 8'h40);
		rchk(eep_pkg::IDX_CTRL, 8'h40);
		apb(1'b0, eep_pkg::IDX_COUNT, 8'h00);
		seed = rd;
		repeat (10) @(posedge i_clock);
		rchk(eep_pkg::IDX_COUNT, seed[7:0]);
		// interrupt gate closed: flag sets, status stays clear
		w(eep_pkg::IDX_STATUS, 8'h03);
		w(eep_pkg::IDX_CTRL, 8'h80);
		repeat (30) @(posedge i_clock);
		rchk(eep_pkg::IDX_STATUS, 8'h00);
		check({31'h0, o_irq}, 32'h0);
		apb(1'b0, eep_pkg::IDX_CTRL, 8'h00);
		check({31'h0, rd[5]}, 32'h1);
		-> stim_done;
	end

	// single place where the run ends
	initial
	begin
		@(stim_done);
		summarize();
	end
endmodule // eep_control_tb
